// ==== dpp_protect.sv ====
// Power detector and transmit-enable sequencer for two converter pairs
// Assumes samples and the settle flag are on clk; transmit-enable pins are asynchronous
`timescale 1ns/1ps
module dpp_protect import dpp_pkg::*; #(
	parameter int SAMPLE_W = 16,
	parameter int POWERUP_CYC = POWERUP_CYCLES
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [8:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [2*SAMPLE_W-1:0] sample_i,
	input wire logic [2*SAMPLE_W-1:0] sample_q,
	input wire logic sample_valid,
	input wire logic [1:0] transmit_enable_in,
	input wire logic [1:0] blanking_settled,
	output logic [1:0] transmit_guard,
	output logic [1:0] power_alarm,
	output logic [1:0] pair_powerdown,
	output logic [1:0] output_valid,
	output logic [1:0] datapath_hold,
	output logic [1:0] downstream_enable_out,
	output logic [1:0] alarm_irq
);
	// Refuse samples narrower than the top bits used and an empty power-up wait
	if (SAMPLE_W < SAMPLE_MSBS || POWERUP_CYC < 1) begin : bad_params
		$error("dpp_protect: bad parameters");
	end
	// Width of the power-up wait counter
	localparam int PU_W = $clog2(POWERUP_CYC + 1);

	// Power of one sample from the top bits of I and Q
	function automatic logic [12:0] sample_power(input logic [SAMPLE_W-1:0] si,
		input logic [SAMPLE_W-1:0] sq);
		logic signed [6:0] ti;
		logic signed [6:0] tq;
		logic signed [13:0] wi;
		logic signed [13:0] wq;
		logic [13:0] sum;
		ti = si[SAMPLE_W-1 -: SAMPLE_MSBS];
		tq = sq[SAMPLE_W-1 -: SAMPLE_MSBS];
		wi = {{7{ti[6]}}, ti};
		wq = {{7{tq[6]}}, tq};
		sum = wi * wi + wq * wq;
		// Both parts at full negative scale give 8192: clamp to the 13-bit top
		return sum[13] ? 13'h1FFF : sum[12:0];
	endfunction

	// Stage length in cycles
	function automatic logic [12:0] stage_len(input logic [7:0] v);
		return 13'(v) * 13'(STAGE_SCALE);
	endfunction

	// ==========================================
	// Shared registers
	logic [7:0] page_reg;
	logic [7:0] pd_masks_reg;
	logic [7:0] irq_en_reg [2];
	logic [1:0] irq_st_reg;
	logic [1:0] irq_clr;
	logic [1:0] sel;
	assign sel = page_reg[1:0];
	assign irq_clr[0] = reg_wr && reg_addr == ADDR_IRQ_ST_A && reg_wdata[BIT_ALARM_IRQ];
	assign irq_clr[1] = reg_wr && reg_addr == ADDR_IRQ_ST_B && reg_wdata[BIT_ALARM_IRQ];

	// Page, masks and interrupt enables
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			page_reg <= RESET_PAGE;
			pd_masks_reg <= RESET_BYTE;
			irq_en_reg[0] <= RESET_BYTE;
			irq_en_reg[1] <= RESET_BYTE;
		end else if (reg_wr) begin
			if (reg_addr == ADDR_PAGE) page_reg <= reg_wdata;
			if (reg_addr == ADDR_PD_MASKS) pd_masks_reg <= reg_wdata;
			if (reg_addr == ADDR_IRQ_EN_A) irq_en_reg[0] <= reg_wdata;
			if (reg_addr == ADDR_IRQ_EN_B) irq_en_reg[1] <= reg_wdata;
		end
	end

	// Per-pair paged registers and state
	logic [7:0] lim_lo_reg [2];
	logic [7:0] lim_hi_reg [2];
	logic [7:0] cfg_reg [2];
	logic [7:0] route_reg [2];
	logic [7:0] stsel_reg [2];
	logic [7:0] rise0_reg [2];
	logic [7:0] rise1_reg [2];
	logic [7:0] fall0_reg [2];
	logic [7:0] fall1_reg [2];
	logic [12:0] meas_reg [2];
	logic [1:0] alarm_reg;
	logic [1:0] alarm_d_reg;
	logic [1:0] tx_meta_reg;
	logic [1:0] tx_sync_reg;
	logic [1:0] tx_d_reg;

	// Two-flop synchroniser for the transmit enable pins
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tx_meta_reg <= 2'h0;
			tx_sync_reg <= 2'h0;
			tx_d_reg <= 2'h0;
			alarm_d_reg <= 2'h0;
		end else begin
			tx_meta_reg <= transmit_enable_in;
			tx_sync_reg <= tx_meta_reg;
			tx_d_reg <= tx_sync_reg;
			alarm_d_reg <= alarm_reg;
		end
	end

	// Alarm interrupt status; a new alarm edge beats a clear
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_st_reg <= 2'h0;
		end else begin
			for (int p = 0; p < 2; p++) begin
				if (!irq_en_reg[p][BIT_ALARM_IRQ]) irq_st_reg[p] <= 1'b0;
				else if (alarm_reg[p] && !alarm_d_reg[p]) irq_st_reg[p] <= 1'b1;
				else if (irq_clr[p]) irq_st_reg[p] <= 1'b0;
			end
		end
	end
	assign alarm_irq = irq_st_reg;
	assign power_alarm = alarm_reg;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : pair
			logic wsel;
			logic [12:0] pow;
			logic [12:0] lim;
			logic [3:0] expo;
			logic [31:0] acc_reg;
			logic [12:0] avg;
			logic [18:0] cnt_reg;
			logic [18:0] win_end;
			logic crossed_reg;
			dpp_seq_type st_reg;
			logic [12:0] tmr_reg;
			logic [PU_W-1:0] pu_reg;
			logic tgt_reg;
			logic [1:0] nstage;
			logic [12:0] len1;
			logic [12:0] len2;
			logic mask;
			assign wsel = reg_wr && sel[g];
			assign pow = sample_power(sample_i[g*SAMPLE_W +: SAMPLE_W],
				sample_q[g*SAMPLE_W +: SAMPLE_W]);
			assign lim = {lim_hi_reg[g][4:0], lim_lo_reg[g]};
			assign expo = cfg_reg[g][3:0] > 4'(MAX_EXPONENT) ? 4'(MAX_EXPONENT)
				: cfg_reg[g][3:0];
			assign mask = g == 0 ? pd_masks_reg[BIT_MASK_A] : pd_masks_reg[BIT_MASK_B];

			// Paged configuration writes
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					lim_lo_reg[g] <= RESET_BYTE;
					lim_hi_reg[g] <= RESET_BYTE;
					cfg_reg[g] <= RESET_BYTE;
					route_reg[g] <= RESET_BYTE;
					stsel_reg[g] <= RESET_STAGE_SEL;
					rise0_reg[g] <= RESET_BYTE;
					rise1_reg[g] <= RESET_BYTE;
					fall0_reg[g] <= RESET_FALL0;
					fall1_reg[g] <= RESET_BYTE;
				end else if (wsel) begin
					if (reg_addr == ADDR_LIMIT_LO) lim_lo_reg[g] <= reg_wdata;
					if (reg_addr == ADDR_LIMIT_HI) lim_hi_reg[g] <= {3'h0, reg_wdata[4:0]};
					if (reg_addr == ADDR_PD_CFG) cfg_reg[g] <= reg_wdata;
					if (reg_addr == ADDR_DS_ROUTE) route_reg[g] <= reg_wdata;
					if (reg_addr == ADDR_STAGE_SEL) stsel_reg[g] <= reg_wdata;
					if (reg_addr == ADDR_RISE0) rise0_reg[g] <= reg_wdata;
					if (reg_addr == ADDR_RISE1) rise1_reg[g] <= reg_wdata;
					if (reg_addr == ADDR_FALL0) fall0_reg[g] <= reg_wdata;
					if (reg_addr == ADDR_FALL1) fall1_reg[g] <= reg_wdata;
				end
			end

			// Block average: sum over 2^(9+n) pairs then shift; one adder,
			// no datapath pipeline, so the alarm lags the samples
			assign avg = 13'(acc_reg >> (BASE_EXPONENT + expo));
			// Last count of a window; a window shortened mid-way ends at once
			assign win_end = 19'((32'd1 << (BASE_EXPONENT + expo)) - 32'd1);
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					acc_reg <= 32'h0;
					cnt_reg <= 19'h0;
					alarm_reg[g] <= 1'b0;
					meas_reg[g] <= 13'h0;
					crossed_reg <= 1'b0;
				end else if (!cfg_reg[g][BIT_PD_ON]) begin
					acc_reg <= 32'h0;
					cnt_reg <= 19'h0;
					alarm_reg[g] <= 1'b0;
					crossed_reg <= 1'b0;
				end else if (sample_valid) begin
					if (cnt_reg >= win_end) begin
						cnt_reg <= 19'h0;
						acc_reg <= 32'(pow);
						if (avg > lim) begin
							alarm_reg[g] <= 1'b1;
							crossed_reg <= 1'b1;
						end else begin
							alarm_reg[g] <= 1'b0;
						end
					end else begin
						cnt_reg <= cnt_reg + 19'h1;
						acc_reg <= acc_reg + 32'(pow);
					end
					if (!crossed_reg) meas_reg[g] <= pow;
					else if (pow > meas_reg[g]) meas_reg[g] <= pow;
				end
			end

			// Delay sequencer: stages run one after another
			assign nstage = tgt_reg ? (stsel_reg[g][5:4] > 2'h2 ? 2'h2 : stsel_reg[g][5:4])
				: (stsel_reg[g][7:6] == 2'h2 ? 2'h2 : 2'h1);
			assign len1 = tgt_reg ? stage_len(rise0_reg[g]) : stage_len(fall0_reg[g]);
			assign len2 = tgt_reg ? stage_len(rise1_reg[g]) : stage_len(fall1_reg[g]);
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					st_reg <= SEQ_IDLE;
					tmr_reg <= 13'h0;
					tgt_reg <= 1'b0;
					transmit_guard[g] <= 1'b0;
				end else begin
					if (tx_sync_reg[g] != tx_d_reg[g]) begin
						tgt_reg <= tx_sync_reg[g];
						st_reg <= SEQ_STAGE1;
						tmr_reg <= 13'h0;
					end else begin
						case (st_reg)
							SEQ_STAGE1: begin
								if (nstage == 2'h0 || tmr_reg >= len1) begin
									tmr_reg <= 13'h0;
									st_reg <= nstage == 2'h2 ? SEQ_STAGE2 : SEQ_SETTLE;
								end else tmr_reg <= tmr_reg + 13'h1;
							end
							SEQ_STAGE2: begin
								if (tmr_reg >= len2) st_reg <= SEQ_SETTLE;
								else tmr_reg <= tmr_reg + 13'h1;
							end
							SEQ_SETTLE: begin
								transmit_guard[g] <= tgt_reg;
								st_reg <= SEQ_IDLE;
							end
							default: st_reg <= SEQ_IDLE;
						endcase
					end
				end
			end

			// Power-down on transmit enable fall, power-up wait afterwards
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					pair_powerdown[g] <= 1'b0;
					pu_reg <= '0;
					output_valid[g] <= 1'b0;
				end else begin
					if (!tx_sync_reg[g] && tx_d_reg[g] && mask) begin
						pair_powerdown[g] <= 1'b1;
						pu_reg <= '0;
					end else if (tx_sync_reg[g] && !tx_d_reg[g]) begin
						pair_powerdown[g] <= 1'b0;
						pu_reg <= pair_powerdown[g] ? PU_W'(POWERUP_CYC) : '0;
					end else if (pu_reg != '0) begin
						pu_reg <= pu_reg - 1'b1;
					end
					output_valid[g] <= transmit_guard[g] && blanking_settled[g]
						&& pu_reg == '0 && !pair_powerdown[g];
				end
			end
			assign datapath_hold[g] = !transmit_guard[g];

			// Downstream enable output combining
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) downstream_enable_out[g] <= 1'b0;
				else downstream_enable_out[g] <= stsel_reg[g][BIT_INVERT_OUT] ^
					!((route_reg[g][BIT_ROUTE_ALARM] && alarm_reg[g]) ||
					(route_reg[g][BIT_ROUTE_GUARD] && !transmit_guard[g]));
			end

			chk_alarm_off: assert property (@(posedge clk) disable iff (!rstn)
				!cfg_reg[g][BIT_PD_ON] |=> !alarm_reg[g])
				else $error("alarm while detector off");
			chk_alarm_window: assert property (@(posedge clk) disable iff (!rstn)
				cfg_reg[g][BIT_PD_ON] && !(sample_valid && cnt_reg >= win_end)
				|=> $stable(alarm_reg[g]))
				else $error("alarm moved inside a window");
			chk_guard_delay: assert property (@(posedge clk) disable iff (!rstn)
				$rose(transmit_guard[g]) |-> tgt_reg && st_reg == SEQ_IDLE)
				else $error("guard rose without sequence");
			chk_pd_mask: assert property (@(posedge clk) disable iff (!rstn)
				(!tx_sync_reg[g] && tx_d_reg[g] && mask) |=> pair_powerdown[g])
				else $error("masked fall did not power down");
			chk_valid_pu: assert property (@(posedge clk) disable iff (!rstn)
				pair_powerdown[g] |=> !output_valid[g])
				else $error("valid while powered down");
			chk_peak_hold: assert property (@(posedge clk) disable iff (!rstn)
				crossed_reg && cfg_reg[g][BIT_PD_ON] |=> meas_reg[g] >= $past(meas_reg[g]))
				else $error("peak readback fell");
			cov_alarm: cover property (@(posedge clk) $rose(alarm_reg[g]));
			cov_guard_up: cover property (@(posedge clk) $rose(transmit_guard[g]));
			cov_powerdown: cover property (@(posedge clk) $rose(pair_powerdown[g]));
		end
	endgenerate

	chk_irq_set: assert property (@(posedge clk) disable iff (!rstn)
		irq_en_reg[0][BIT_ALARM_IRQ] && $rose(alarm_reg[0]) |=> irq_st_reg[0])
		else $error("pair A irq not set");
	// A cleared enable leaves the pending flag low from the next cycle on
	chk_irq_off: assert property (@(posedge clk) disable iff (!rstn)
		!irq_en_reg[0][BIT_ALARM_IRQ] |=> !irq_st_reg[0])
		else $error("pair A irq set while disabled");
	chk_irq_clr: assert property (@(posedge clk) disable iff (!rstn)
		irq_clr[1] && !(alarm_reg[1] && !alarm_d_reg[1]) |=> !irq_st_reg[1])
		else $error("pair B irq not cleared");
	chk_rise_none: assert property (@(posedge clk) disable iff (!rstn)
		tx_sync_reg[0] && !tx_d_reg[0] && stsel_reg[0][5:4] == 2'h0 &&
		!(reg_wr && reg_addr == ADDR_STAGE_SEL) |=> ##2 transmit_guard[0])
		else $error("zero-stage rise too slow");

	// Read mux, page-selected; lowest selected pair answers
	logic p;
	assign p = sel[0] ? 1'b0 : 1'b1;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) reg_rdata <= RESET_BYTE;
		else if (reg_rd) begin
			case (reg_addr)
				ADDR_PAGE: reg_rdata <= page_reg;
				ADDR_PD_MASKS: reg_rdata <= pd_masks_reg;
				ADDR_IRQ_EN_A: reg_rdata <= irq_en_reg[0];
				ADDR_IRQ_EN_B: reg_rdata <= irq_en_reg[1];
				ADDR_IRQ_ST_A: reg_rdata <= {irq_st_reg[0], 7'h0};
				ADDR_IRQ_ST_B: reg_rdata <= {irq_st_reg[1], 7'h0};
				ADDR_DS_ROUTE: reg_rdata <= route_reg[p];
				ADDR_LIMIT_LO: reg_rdata <= lim_lo_reg[p];
				ADDR_LIMIT_HI: reg_rdata <= lim_hi_reg[p];
				ADDR_PD_CFG: reg_rdata <= cfg_reg[p];
				ADDR_POW_LO: reg_rdata <= meas_reg[p][7:0];
				ADDR_POW_HI: reg_rdata <= {3'h0, meas_reg[p][12:8]};
				ADDR_STAGE_SEL: reg_rdata <= stsel_reg[p];
				ADDR_RISE0: reg_rdata <= rise0_reg[p];
				ADDR_RISE1: reg_rdata <= rise1_reg[p];
				ADDR_FALL0: reg_rdata <= fall0_reg[p];
				ADDR_FALL1: reg_rdata <= fall1_reg[p];
				default: reg_rdata <= RESET_BYTE;
			endcase
		end
	end
endmodule

// ==== dpp_pkg.sv ====
// Constants for the downstream power protection block
// Assumes an 8-bit register port with 9-bit byte addresses
package dpp_pkg;
	// ==========================================
	// Register offsets
	localparam logic [8:0] ADDR_PD_MASKS = 9'h012;
	localparam logic [8:0] ADDR_DS_ROUTE = 9'h013;
	localparam logic [8:0] ADDR_IRQ_EN_A = 9'h021;
	localparam logic [8:0] ADDR_IRQ_EN_B = 9'h022;
	localparam logic [8:0] ADDR_IRQ_ST_A = 9'h025;
	localparam logic [8:0] ADDR_IRQ_ST_B = 9'h026;
	localparam logic [8:0] ADDR_PAGE = 9'h008;
	localparam logic [8:0] ADDR_LIMIT_LO = 9'h060;
	localparam logic [8:0] ADDR_LIMIT_HI = 9'h061;
	localparam logic [8:0] ADDR_PD_CFG = 9'h062;
	localparam logic [8:0] ADDR_POW_LO = 9'h063;
	localparam logic [8:0] ADDR_POW_HI = 9'h064;
	localparam logic [8:0] ADDR_STAGE_SEL = 9'h11F;
	localparam logic [8:0] ADDR_RISE0 = 9'h121;
	localparam logic [8:0] ADDR_RISE1 = 9'h122;
	localparam logic [8:0] ADDR_FALL0 = 9'h123;
	localparam logic [8:0] ADDR_FALL1 = 9'h124;
	// ==========================================
	// Field positions, widths and scale factors
	localparam int BIT_PD_ON = 7;
	localparam int BIT_MASK_A = 6;
	localparam int BIT_MASK_B = 7;
	localparam int BIT_ALARM_IRQ = 7;
	localparam int BIT_ROUTE_ALARM = 6;
	localparam int BIT_ROUTE_GUARD = 5;
	localparam int BIT_INVERT_OUT = 2;
	localparam int SAMPLE_MSBS = 7;
	localparam int MAX_EXPONENT = 10;
	localparam int BASE_EXPONENT = 9;
	localparam int STAGE_SCALE = 32;
	localparam logic [7:0] MIN_FALL_COUNT = 8'h12;
	// ==========================================
	// Reset values
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] RESET_STAGE_SEL = 8'h40;
	localparam logic [7:0] RESET_FALL0 = 8'h12;
	localparam logic [7:0] RESET_PAGE = 8'h03;
	// ==========================================
	// Timing
	localparam int CLK_MHZ = 25;
	localparam int POWERUP_US = 35;
	localparam int POWERUP_CYCLES = POWERUP_US * CLK_MHZ;
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_STAGE1 = 2'b01,
		SEQ_STAGE2 = 2'b10,
		SEQ_SETTLE = 2'b11
	} dpp_seq_type;
endpackage

// ==== dpp_blank_model.sv ====
// Behavioural stand-in for the blanking sequencer beside each converter pair
// Assumes the guard outputs of the protection block on the same clock
`timescale 1ns/1ps
module dpp_blank_model #(
	parameter int SETTLE_CYC = 4
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [1:0] transmit_guard,
	output logic [1:0] blanking_settled
);
	logic [7:0] ramp_cnt_reg[2];
	// ==========================================
	// Ramp timing
	// Settles a few cycles after the guard rises, drops at once when it falls
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ramp_cnt_reg[0] <= 8'h00;
			ramp_cnt_reg[1] <= 8'h00;
			blanking_settled <= 2'b00;
		end else begin
			for (int p = 0; p < 2; p++) begin
				if (!transmit_guard[p]) begin
					ramp_cnt_reg[p] <= 8'h00;
					blanking_settled[p] <= 1'b0;
				end else if (ramp_cnt_reg[p] < 8'(SETTLE_CYC)) begin
					ramp_cnt_reg[p] <= ramp_cnt_reg[p] + 8'h01;
				end else begin
					blanking_settled[p] <= 1'b1;
				end
			end
		end
	end
endmodule

// ==== testbench.sv ====
// Self-checking bench for the downstream power protection block
// Assumes the blanking model answers the guard; power-up count shortened to 8
`timescale 1ns/1ps
module testbench;
	import dpp_pkg::*;
	logic clk, rstn, reg_wr, reg_rd;
	logic [8:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rv;
	logic [31:0] sample_i, sample_q;
	logic sample_valid;
	logic [1:0] transmit_enable_in, blanking_settled, transmit_guard, power_alarm;
	logic [1:0] pair_powerdown, output_valid, datapath_hold, downstream_enable_out, alarm_irq;
	int error_cnt = 0;
	int checks_done = 0;
	int n;
	// ==========================================
	// Design and far side
	dpp_protect #(.SAMPLE_W(16), .POWERUP_CYC(8)) i_dut (.clk(clk), .rstn(rstn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sample_i(sample_i), .sample_q(sample_q),
		.sample_valid(sample_valid), .transmit_enable_in(transmit_enable_in),
		.blanking_settled(blanking_settled), .transmit_guard(transmit_guard),
		.power_alarm(power_alarm), .pair_powerdown(pair_powerdown),
		.output_valid(output_valid), .datapath_hold(datapath_hold),
		.downstream_enable_out(downstream_enable_out), .alarm_irq(alarm_irq));
	dpp_blank_model i_blank (.clk(clk), .rstn(rstn), .transmit_guard(transmit_guard),
		.blanking_settled(blanking_settled));
	// ==========================================
	// Clock and watchdog
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		repeat (60000) @(posedge clk);
		error_cnt++;
		complete_run();
	end
	// ==========================================
	// Shared tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [8:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	// Counts cycles until the guard reaches v, then tests the span
	task automatic wait_guard(input logic [1:0] v, input int lo, input int hi);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (transmit_guard !== v && n < 3000);
		chk({15'h0000, n >= lo && n <= hi}, 16'h0001);
	endtask
	task automatic complete_run();
		if (error_cnt == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ==========================================
	// Main sequence
	initial begin
		rstn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 9'h000;
		reg_wdata = 8'h00;
		sample_i = 32'h0000_0000;
		sample_q = 32'h0000_0000;
		sample_valid = 1'b0;
		transmit_enable_in = 2'b00;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		// Reset values, a read-only write and an unmapped read
		wr(ADDR_POW_LO, 8'hFF);
		rd(ADDR_STAGE_SEL, rv); chk(rv, 8'h40);
		rd(ADDR_FALL0, rv); chk(rv, 8'h12);
		rd(ADDR_POW_LO, rv); chk(rv, 8'h00);
		rd(9'h1FF, rv); chk(rv, 8'h00);
		// Power detector: 63 squared per pair, limit one below it
		wr(ADDR_LIMIT_LO, 8'h80);
		wr(ADDR_LIMIT_HI, 8'h0F);
		wr(ADDR_IRQ_EN_A, 8'h80);
		wr(ADDR_IRQ_EN_B, 8'h80);
		wr(ADDR_DS_ROUTE, 8'h40);
		rd(ADDR_LIMIT_LO, rv); chk(rv, 8'h80);
		rd(ADDR_LIMIT_HI, rv); chk(rv, 8'h0F);
		// Paging: a write to pair A alone leaves pair B as it was
		wr(ADDR_PAGE, 8'h01);
		wr(ADDR_LIMIT_LO, 8'h11);
		rd(ADDR_LIMIT_LO, rv); chk(rv, 8'h11);
		wr(ADDR_PAGE, 8'h02);
		rd(ADDR_LIMIT_LO, rv); chk(rv, 8'h80);
		wr(ADDR_PAGE, 8'h03);
		wr(ADDR_LIMIT_LO, 8'h80);
		sample_i <= 32'h7E1F_7E1F;
		sample_q <= 32'h01FF_01FF;
		sample_valid <= 1'b1;
		repeat (2000) @(posedge clk);
		chk(power_alarm, 2'b00);
		wr(ADDR_PD_CFG, 8'h80);
		rd(ADDR_PD_CFG, rv); chk(rv, 8'h80);
		n = 0;
		while (power_alarm !== 2'b11 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		#1;
		chk(power_alarm, 2'b11);
		chk(downstream_enable_out, 2'b00);
		chk(alarm_irq, 2'b11);
		rd(ADDR_POW_LO, rv); chk(rv, 8'h81);
		rd(ADDR_POW_HI, rv); chk(rv, 8'h0F);
		rd(ADDR_IRQ_ST_A, rv); chk(rv[7], 1'b1);
		wr(ADDR_IRQ_ST_A, 8'h80);
		wr(ADDR_IRQ_ST_B, 8'h80);
		@(posedge clk);
		#1;
		chk(alarm_irq, 2'b00);
		wr(ADDR_STAGE_SEL, 8'h44);
		@(posedge clk);
		#1;
		chk(downstream_enable_out, 2'b11);
		wr(ADDR_STAGE_SEL, 8'h40);
		// Guard with no rise counters and no masks
		transmit_enable_in <= 2'b11;
		wait_guard(2'b11, 1, 8);
		chk(datapath_hold, 2'b00);
		repeat (20) @(posedge clk);
		#1;
		chk(output_valid, 2'b11);
		// Falling edge with both masks set powers both pairs down
		wr(ADDR_PD_MASKS, 8'hC0);
		transmit_enable_in <= 2'b00;
		wait_guard(2'b00, 576, 590);
		chk(pair_powerdown, 2'b11);
		chk(datapath_hold, 2'b11);
		chk(output_valid, 2'b00);
		// One rise counter of 2
		wr(ADDR_STAGE_SEL, 8'h50);
		wr(ADDR_RISE0, 8'h02);
		transmit_enable_in <= 2'b11;
		wait_guard(2'b11, 64, 74);
		chk(output_valid, 2'b00);
		repeat (40) @(posedge clk);
		#1;
		chk(output_valid, 2'b11);
		chk(pair_powerdown, 2'b00);
		// Two rise and two fall counters run in sequence
		wr(ADDR_STAGE_SEL, 8'hA0);
		wr(ADDR_RISE1, 8'h01);
		wr(ADDR_FALL1, 8'h01);
		transmit_enable_in <= 2'b00;
		wait_guard(2'b00, 608, 622);
		transmit_enable_in <= 2'b11;
		wait_guard(2'b11, 96, 108);
		complete_run();
	end
endmodule
